// >>> integrity_pkg.sv
// Types shared by the integrity monitor
// Assumes nothing beyond the register header
package integrity_pkg;
   typedef enum logic [1:0] {
      clk_main = 2'b01,
      clk_safe = 2'b10
   } clk_state_e;
endpackage

// >>> integrity_regs.svh
// Register offsets, field positions and reset values of the integrity monitor
// Assumes an APB slave with 32-bit data, one register per aligned word
`ifndef INTEGRITY_REGS_SVH
`define INTEGRITY_REGS_SVH
`define ICS_OFFSET 12'h000
`define ICS_SRC_BIT 7
`define ICS_VIE_BIT 6
`define ICS_VDF_BIT 5
`define ICS_LVRF_BIT 4
`define ICS_RSVD_BIT 3
`define ICS_CFIE_BIT 2
`define ICS_CFF_BIT 1
`define ICS_WDRF_BIT 0
`define ICS_RESET 8'h00
`endif

// >>> isr_model.sv
// Interrupt controller and CPU service entry for the integrity monitor
// Assumes level requests; acknowledge pulses one cycle on entry
`timescale 1ns/1ns
module isr_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic voltage_irq,
   input wire logic clock_fail_irq,
   output logic voltage_irq_ack,
   output logic clock_fail_irq_ack
);
   logic [3:0] vw, cw, lat;
   assign lat = slow ? 4'h9 : 4'h3;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vw <= 4'h0;
         cw <= 4'h0;
         voltage_irq_ack <= 1'b0;
         clock_fail_irq_ack <= 1'b0;
      end else begin
         vw <= (voltage_irq && !voltage_irq_ack) ? vw + 4'h1 : 4'h0;
         cw <= (clock_fail_irq && !clock_fail_irq_ack) ? cw + 4'h1 : 4'h0;
         voltage_irq_ack <= voltage_irq && vw == lat;
         clock_fail_irq_ack <= clock_fail_irq && cw == lat;
      end
   end
endmodule

// >>> sim_chk.sv
// Checker of the integrity monitor, bound to its top module
// Assumes APB answers one cycle after setup, pins synchronised
`timescale 1ns/1ns
module sim_chk (
   input wire logic pclk, presetn, psel, penable, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic main_osc_ok, css_option, pll_enable, halt_mode,
   input wire logic cpu_irq_mask, use_safe_clock, glitch_filter_on,
   input wire logic voltage_irq, clock_fail_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("late pready");
   property p_unmap;
      psel && !penable && paddr[11:2] != 10'h000 |=> pslverr;
   endproperty
   a_unmap: assert property (p_unmap) else $error("no slave error");
   property p_mask; cpu_irq_mask |=> !voltage_irq && !clock_fail_irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq masked");
   property p_safe_on;
      (!main_osc_ok && css_option && !halt_mode)[*8] |-> use_safe_clock;
   endproperty
   a_safe_on: assert property (p_safe_on) else $error("no safe");
   property p_safe_off; main_osc_ok[*8] |-> !use_safe_clock; endproperty
   a_safe_off: assert property (p_safe_off) else $error("stuck");
   property p_halt; halt_mode[*3] |-> !use_safe_clock; endproperty
   a_halt: assert property (p_halt) else $error("safe in halt");
   property p_filt; (css_option && pll_enable)[*3] |-> glitch_filter_on;
   endproperty
   a_filt: assert property (p_filt) else $error("filter off");
   property p_cssoff; !css_option[*3] |-> !clock_fail_irq; endproperty
   a_cssoff: assert property (p_cssoff) else $error("clock irq");
   c_v: cover property (voltage_irq);
   c_c: cover property (clock_fail_irq);
   c_s: cover property (use_safe_clock);
endmodule
bind system_integrity_monitor sim_chk chk (.*);

// >>> system_integrity_monitor.sv
// System integrity monitor: voltage detector, clock security, reset flags
// Assumes analog and oscillator status arrive as asynchronous pins
`timescale 1ns/1ns
`include "integrity_regs.svh"

// Notes on behaviour
// - Bit 7 selects external detect pin when set, main supply when clear.
// - Voltage detection works only when low voltage reset option is on.
// - Bit 5 read-only, follows comparator: 1 below threshold, 0 above.
// - With enable set, every toggle of the detect flag requests interrupt.
// - Bit 6 enable is read/write; pending cleared on service entry.
// - Glitch filter on main oscillator active only with multiplier on.
// - Main clock loss switches CPU clock to the safe oscillator.
// - Main oscillator recovery switches back automatically.
// - Bit 1 set on safe clock use, cleared by read after recovery.
// - Clock security disabled: fail flag reads 0, its enable inert.
// - Bit 2 enable read/write; set flag then raises an interrupt.
// - Events interrupt only when CPU unmasked; both wake from wait.
// - In halt the register freezes and clock security stops.
// - Bit 4 set by low voltage reset, cleared by software zero write.
// - Low voltage flag survives later pin or watchdog resets.
// - Bit 0 set by watchdog reset, cleared by zero write or low voltage.
// - Flags encode cause: 00 pin, 01 watchdog, 1x low voltage.
// - Register resets to 00h, cause flags depend on reset source.
// - Enabling while still low gives one interrupt now, one at crossing.
module system_integrity_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_cmp,
   input wire logic external_detect_pin,
   input wire logic main_osc_ok,
   input wire logic lvd_option,
   input wire logic css_option,
   input wire logic pll_enable,
   input wire logic cause_lvd,
   input wire logic cause_wdg,
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic cpu_irq_mask,
   input wire logic voltage_irq_ack,
   input wire logic clock_fail_irq_ack,
   output logic use_safe_clock,
   output logic glitch_filter_on,
   output logic voltage_irq,
   output logic clock_fail_irq,
   output logic wake_from_wait
);
   // Three-stage synchronisers for pins
   logic [2:0] sup_s, ext_s, osc_s;
   logic sup_q, ext_q, osc_q;
   logic src_sel, v_ie, vdf, lvrf, cf_ie, cff, wdrf;
   logic v_pend, cf_pend;
   integrity_pkg::clk_state_e clk_st;
   logic cmp_now, css_active;
   logic wr_acc, rd_acc, hit;
   logic [7:0] reg_val;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_s <= 3'h0;
         ext_s <= 3'h0;
         osc_s <= 3'h7;
      end else begin
         sup_s <= {sup_s[1:0], supply_cmp};
         ext_s <= {ext_s[1:0], external_detect_pin};
         osc_s <= {osc_s[1:0], main_osc_ok};
      end
   end

   // Change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_q <= 1'b0;
         ext_q <= 1'b0;
         osc_q <= 1'b1;
      end else begin
         if (sup_s[2] == sup_s[1])
            sup_q <= sup_s[2];
         if (ext_s[2] == ext_s[1])
            ext_q <= ext_s[2];
         if (osc_s[2] == osc_s[1])
            osc_q <= osc_s[2];
      end
   end

   assign cmp_now = lvd_option & (src_sel ? ext_q : sup_q);
   assign css_active = css_option & ~halt_mode;

   assign hit = (paddr[11:2] == 10'(`ICS_OFFSET >> 2));
   assign wr_acc = psel & penable & pwrite & hit & ~halt_mode;
   assign rd_acc = psel & penable & ~pwrite & hit;

   function automatic logic lane0_wr(input logic w, input logic [3:0] s);
      lane0_wr = w & s[0];
   endfunction

   // Software control bits, frozen in halt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_sel <= 1'b0;
         v_ie <= 1'b0;
         cf_ie <= 1'b0;
      end else if (lane0_wr(wr_acc, pstrb)) begin
         src_sel <= pwdata[`ICS_SRC_BIT];
         v_ie <= pwdata[`ICS_VIE_BIT];
         cf_ie <= pwdata[`ICS_CFIE_BIT];
      end
   end

   // Detect flag tracks comparator, not frozen by bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         vdf <= 1'b0;
      else if (!halt_mode)
         vdf <= cmp_now;
   end

   // Voltage pending: toggle or enable while low; set beats ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         v_pend <= 1'b0;
      else if (!halt_mode && v_ie && vdf != cmp_now)
         v_pend <= 1'b1;
      else if (lane0_wr(wr_acc, pstrb) && !v_ie && pwdata[`ICS_VIE_BIT]
               && vdf)
         v_pend <= 1'b1;
      else if (voltage_irq_ack || !v_ie)
         v_pend <= 1'b0;
   end

   // Clock source selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clk_st <= integrity_pkg::clk_main;
      else begin
         case (clk_st)
            integrity_pkg::clk_main: begin
               if (css_active && !osc_q)
                  clk_st <= integrity_pkg::clk_safe;
            end
            integrity_pkg::clk_safe: begin
               if (!css_active || osc_q)
                  clk_st <= integrity_pkg::clk_main;
            end
            default:
               clk_st <= integrity_pkg::clk_main;
         endcase
      end
   end

   // Clock fail flag: set wins over read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cff <= 1'b0;
      else if (!css_option)
         cff <= 1'b0;
      else if (halt_mode)
         cff <= cff;
      else if (clk_st == integrity_pkg::clk_safe)
         cff <= 1'b1;
      else if (rd_acc && osc_q)
         cff <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cf_pend <= 1'b0;
      else if (css_option && cf_ie && !halt_mode && !cff
               && clk_st == integrity_pkg::clk_safe)
         cf_pend <= 1'b1;
      else if (clock_fail_irq_ack || !cf_ie || !css_option)
         cf_pend <= 1'b0;
   end

   // Low voltage flag has no reset, so later resets keep it
   always_ff @(posedge pclk) begin
      if (cause_lvd)
         lvrf <= 1'b1;
      else if (lane0_wr(wr_acc, pstrb) && !pwdata[`ICS_LVRF_BIT])
         lvrf <= 1'b0;
   end

   // Watchdog flag; causes sampled on edges after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wdrf <= 1'b0;
      else if (cause_lvd)
         wdrf <= 1'b0;
      else if (cause_wdg)
         wdrf <= 1'b1;
      else if (lane0_wr(wr_acc, pstrb) && !pwdata[`ICS_WDRF_BIT])
         wdrf <= 1'b0;
   end

   always_comb begin
      reg_val = 8'h00;
      reg_val[`ICS_SRC_BIT] = src_sel;
      reg_val[`ICS_VIE_BIT] = v_ie;
      reg_val[`ICS_VDF_BIT] = vdf;
      reg_val[`ICS_LVRF_BIT] = lvrf;
      reg_val[`ICS_RSVD_BIT] = 1'b0;
      reg_val[`ICS_CFIE_BIT] = cf_ie;
      reg_val[`ICS_CFF_BIT] = cff & css_option;
      reg_val[`ICS_WDRF_BIT] = wdrf;
   end

   // APB answer: zero-wait, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         if (psel && !penable && !pwrite && hit)
            prdata <= {24'h0, reg_val};
         else
            prdata <= 32'h0;
      end
   end

   // Outputs to clocking and interrupt controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         use_safe_clock <= 1'b0;
         glitch_filter_on <= 1'b0;
         voltage_irq <= 1'b0;
         clock_fail_irq <= 1'b0;
         wake_from_wait <= 1'b0;
      end else begin
         use_safe_clock <= (clk_st == integrity_pkg::clk_safe);
         glitch_filter_on <= css_option & pll_enable;
         voltage_irq <= v_pend & ~cpu_irq_mask;
         clock_fail_irq <= cf_pend & ~cpu_irq_mask;
         wake_from_wait <= wait_mode & (v_pend | cf_pend);
      end
   end
endmodule

// >>> tb.sv
// Testbench of the system integrity monitor
// Assumes the design, sim_chk and isr_model are compiled first
`timescale 1ns/1ns
`include "integrity_regs.svh"
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, supply_cmp = 1'b0, external_detect_pin = 1'b0;
   logic main_osc_ok = 1'b1, lvd_option = 1'b1, css_option = 1'b1;
   logic pll_enable = 1'b1, cause_lvd = 1'b0, cause_wdg = 1'b0;
   logic halt_mode = 1'b0, wait_mode = 1'b0, cpu_irq_mask = 1'b0;
   logic slow = 1'b0, pready, pslverr, err, voltage_irq_ack;
   logic clock_fail_irq_ack, use_safe_clock, glitch_filter_on;
   logic voltage_irq, clock_fail_irq, wake_from_wait;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   int error_cnt = 0, check_count = 0, vc = 0, cc = 0, v0;
   always #2 pclk = ~pclk;
   always @(posedge voltage_irq) vc++;
   always @(posedge clock_fail_irq) cc++;
   system_integrity_monitor dut (.*);
   isr_model psr (.*);
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rc(input string n, input logic [31:0] e);
      apb(1'b0, `ICS_OFFSET, 8'h00);
      chk(n, e, rd);
   endtask
   task automatic rst(input logic l, w);
      presetn <= 1'b0;
      cause_lvd <= l;
      cause_wdg <= w;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      cause_lvd <= 1'b0;
      cause_wdg <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_cause;
      rst(1'b1, 1'b0);
      rc("lvd", 32'h10);
      rst(1'b0, 1'b1);
      rc("keep", 32'h11);
      apb(1'b1, `ICS_OFFSET, 8'h00);
      rc("clr", 32'h00);
      rst(1'b0, 1'b1);
      rc("wdg", 32'h01);
      rst(1'b1, 1'b0);
      rc("lvd_wdg", 32'h10);
      apb(1'b1, `ICS_OFFSET, 8'h00);
      rst(1'b0, 1'b0);
      rc("pin", 32'h00);
      apb(1'b0, 12'h004, 8'h00);
      chk("slverr", 32'h1, err);
      apb(1'b1, `ICS_OFFSET, 8'hc4);
      rc("ctl", 32'hc4);
   endtask
   task automatic t_volt;
      apb(1'b1, `ICS_OFFSET, 8'h40);
      v0 = vc;
      supply_cmp <= 1'b1;
      repeat (12) @(posedge pclk);
      rc("below", 32'h60);
      supply_cmp <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("both_edges", v0 + 2, vc);
      apb(1'b1, `ICS_OFFSET, 8'h80);
      external_detect_pin <= 1'b1;
      repeat (12) @(posedge pclk);
      rc("pin_src", 32'ha0);
      apb(1'b1, `ICS_OFFSET, 8'hc0);
      repeat (12) @(posedge pclk);
      external_detect_pin <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("enable_low", v0 + 4, vc);
      cpu_irq_mask <= 1'b1;
      wait_mode <= 1'b1;
      slow <= 1'b1;
      external_detect_pin <= 1'b1;
      repeat (12) @(posedge pclk);
      chk("masked", v0 + 4, vc);
      chk("wake", 32'h1, wake_from_wait);
      cpu_irq_mask <= 1'b0;
      wait_mode <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("unmasked", v0 + 5, vc);
      lvd_option <= 1'b0;
      repeat (12) @(posedge pclk);
      rc("lvd_off", 32'hc0);
   endtask
   task automatic t_clock;
      chk("filt_on", 32'h1, glitch_filter_on);
      apb(1'b1, `ICS_OFFSET, 8'h04);
      v0 = cc;
      main_osc_ok <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("safe", 32'h1, use_safe_clock);
      chk("cf_irq", v0 + 1, cc);
      rc("cff_hold", 32'h06);
      main_osc_ok <= 1'b1;
      repeat (12) @(posedge pclk);
      chk("main", 32'h0, use_safe_clock);
      rc("cff_read", 32'h06);
      rc("cff_clr", 32'h04);
      halt_mode <= 1'b1;
      apb(1'b1, `ICS_OFFSET, 8'h00);
      rc("halt", 32'h04);
      pll_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("filt_off", 32'h0, glitch_filter_on);
      halt_mode <= 1'b0;
      css_option <= 1'b0;
      main_osc_ok <= 1'b0;
      repeat (12) @(posedge pclk);
      rc("css_off", 32'h04);
      chk("css_irq", v0 + 1, cc);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      t_cause;
      t_volt;
      t_clock;
      tally_and_finish;
   end
   initial begin
      #100000;
      error_cnt++;
      tally_and_finish;
   end
endmodule
